// File: logic/opp_cfg.svh
`ifndef OPP_CFG_SVH
`define OPP_CFG_SVH

// ****************************************************************
// Register indices; the bus byte address is four times the index.
// ****************************************************************
`define OPP_IDX_LEVELS   16'hf228
`define OPP_IDX_DRV_LO   16'hf22a
`define OPP_IDX_DRV_HI   16'hf22b
`define OPP_IDX_FUNC_LO  16'hf22c
`define OPP_IDX_FUNC_HI  16'hf22d
`define OPP_IDX_W        16

// ****************************************************************
// Field layout and reset values.
// ****************************************************************
`define OPP_PIN_CNT      4
`define OPP_FIELD_LSB    0
`define OPP_FIELD_MSB    3
`define OPP_WORD_HI_LSB  8
`define OPP_WORD_HI_MSB  11
`define OPP_RST_FIELD    4'h0

`endif

// File: logic/opp_pkg.sv
`default_nettype none
// ****************************************************************
// Shared types of the four-bit output port.
// ****************************************************************
package opp_pkg;

  typedef enum logic [1:0] {
    DRV_HIZ    = 2'h0,
    DRV_PCH_OD = 2'h1,
    DRV_NCH_OD = 2'h2,
    DRV_CMOS   = 2'h3
  } opp_drive_t;

  typedef enum logic [1:0] {
    FN_GENERAL = 2'h0,
    FN_ALT_A   = 2'h1,
    FN_ALT_B   = 2'h2,
    FN_ALT_C   = 2'h3
  } opp_func_t;

  typedef logic [3:0] opp_nib_t;

endpackage : opp_pkg

`default_nettype wire

// File: logic/opp_nib_reg.sv
`timescale 1ns/10ps
`default_nettype none
`include "opp_cfg.svh"

// ****************************************************************
// One four-bit control field with write enable.
// ****************************************************************
module opp_nib_reg
  import opp_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          nrst,
  input  wire logic          ce,
  input  wire logic          wr_en,
  input  wire opp_pkg::opp_nib_t wdata,
  output opp_pkg::opp_nib_t      q
);

  opp_nib_t field_reg;

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      field_reg <= `OPP_RST_FIELD;
    else if (ce && wr_en)
      field_reg <= wdata;
  end

  assign q = field_reg;

endmodule : opp_nib_reg

`default_nettype wire

// File: logic/opp_pin_drive.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Function select and output driver of one pin.
// ****************************************************************
module opp_pin_drive
  import opp_pkg::*;
#(
  parameter logic [3:0] CODE_OK = 4'h7
)
(
  input  wire logic                core_clk,
  input  wire logic                nrst,
  input  wire logic                ce,
  input  wire logic                level,
  input  wire opp_pkg::opp_func_t  func,
  input  wire opp_pkg::opp_drive_t drive,
  input  wire logic                alt_a,
  input  wire logic                alt_b,
  input  wire logic                alt_c,
  output logic                     pin_out,
  output logic                     pin_oe,
  output logic                     led_mode
);

  logic out_reg;
  logic oe_reg;
  logic led_reg;
  logic use_alt;
  logic alt_val;
  logic value;
  logic oe_next;

  // Unused codes fall back to the data bit rather than a dead pin.
  assign use_alt = CODE_OK[func] && (func != FN_GENERAL); // [R13] [R14]
  assign alt_val = (func == FN_ALT_A) ? alt_a :
                   (func == FN_ALT_B) ? alt_b : alt_c;
  assign value   = use_alt ? alt_val : level; // [R3] [R16]

  // Open drain halves drive only the level they own.
  assign oe_next = (drive == DRV_CMOS)   ? 1'b1   :
                   (drive == DRV_PCH_OD) ? value  :
                   (drive == DRV_NCH_OD) ? ~value : 1'b0; // [R4] [R16]

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      out_reg <= 1'b0;
      oe_reg  <= 1'b0;
      led_reg <= 1'b1;
    end
    else if (ce)
    begin
      out_reg <= value;
      oe_reg  <= oe_next;
      led_reg <= (func == FN_GENERAL); // [R11]
    end
  end

  assign pin_out  = out_reg;
  assign pin_oe   = oe_reg;
  assign led_mode = led_reg;

endmodule : opp_pin_drive

`default_nettype wire

// File: logic/opp_port_top.sv
// Operation
// R1 - Four output-only pins, no input path, no direction register.
// R2 - Pins follow the level register; reads return the last written value.
// R3 - Level bit n drives pin n; zero is low, one is high.
// R4 - Drive field {high,low}: Hi-Z, P open drain, N open drain, CMOS.
// R5 - All registers reset to zero; pins start Hi-Z with low data.
// R6 - Drive low register takes byte or 16-bit word; high takes bytes.
// R7 - Function low register takes byte or word covering function high.
// R8 - Secondary: slow clock on pin 0, fast clock on pin 1.
// R9 - Tertiary: PWM four, PWM five, timer one, timer two on pins 0-3.
// R10 - Quartic: PWM six on pin 2, PWM seven on pin 3.
// R11 - General output function puts the pin in LED drive mode.
// R12 - Software should pick N open drain for pins driving LEDs.
// R13 - Pins 0,1 codes: 00 general, 01 clock, 10 PWM, 11 unused.
// R14 - Pins 2,3 codes: 00 general, 01 unused, 10 timer, 11 PWM.
// R15 - Register bits 7 to 4 read zero and ignore writes.
// R16 - An alternate function replaces the data bit; drive state still applies.
`timescale 1ns/10ps
`default_nettype none
`include "opp_cfg.svh"

module opp_port_top
  import opp_pkg::*;
#(
  parameter int ADDR_W = 18
)
(
  input  wire logic              core_clk,
  input  wire logic              nrst,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              slow_clock_out,
  input  wire logic              fast_clock_out,
  input  wire logic              pwm_ch_four,
  input  wire logic              pwm_ch_five,
  input  wire logic              pwm_ch_six,
  input  wire logic              pwm_ch_seven,
  input  wire logic              timer_first_out,
  input  wire logic              timer_second_out,
  output logic [3:0]             pin_out,
  output logic [3:0]             pin_oe,
  output logic [3:0]             led_drive_mode
);

  import opp_pkg::*;

  // ****************************************************************
  // Parameter checks.
  // ****************************************************************
  if (ADDR_W < `OPP_IDX_W + 2)
  begin : g_addr_chk
    $error("ADDR_W too narrow for the register map");
  end

  // ****************************************************************
  // Address decode.
  // ****************************************************************
  localparam logic [ADDR_W-1:0] A_LEVELS  = ADDR_W'({`OPP_IDX_LEVELS, 2'h0});
  localparam logic [ADDR_W-1:0] A_DRV_LO  = ADDR_W'({`OPP_IDX_DRV_LO, 2'h0});
  localparam logic [ADDR_W-1:0] A_DRV_HI  = ADDR_W'({`OPP_IDX_DRV_HI, 2'h0});
  localparam logic [ADDR_W-1:0] A_FUNC_LO = ADDR_W'({`OPP_IDX_FUNC_LO, 2'h0});
  localparam logic [ADDR_W-1:0] A_FUNC_HI = ADDR_W'({`OPP_IDX_FUNC_HI, 2'h0});

  logic hit_levels;
  logic hit_drv_lo;
  logic hit_drv_hi;
  logic hit_func_lo;
  logic hit_func_hi;
  logic hit_any;

  assign hit_levels  = (paddr == A_LEVELS);
  assign hit_drv_lo  = (paddr == A_DRV_LO);
  assign hit_drv_hi  = (paddr == A_DRV_HI);
  assign hit_func_lo = (paddr == A_FUNC_LO);
  assign hit_func_hi = (paddr == A_FUNC_HI);
  assign hit_any     = hit_levels | hit_drv_lo | hit_drv_hi | hit_func_lo | hit_func_hi;

  // ****************************************************************
  // Bus handshake.
  // ****************************************************************
  // The answer is prepared in the setup cycle so that every bus output
  // comes from a flop; this costs one wait-free access phase only.
  logic        pready_reg;
  logic        pslverr_reg;
  logic [31:0] prdata_reg;
  logic        setup_ph;
  logic        bus_wr;

  assign setup_ph = psel & ~penable;
  assign bus_wr   = psel & penable & pwrite & pready_reg & hit_any & ce;

  // ****************************************************************
  // Write enables; a word access at a low register also fills its partner.
  // ****************************************************************
  logic     wr_levels;
  logic     wr_drv_lo;
  logic     wr_drv_hi;
  logic     wr_func_lo;
  logic     wr_func_hi;
  opp_nib_t wd_low;
  opp_nib_t wd_word_hi;

  assign wd_low     = pwdata[`OPP_FIELD_MSB:`OPP_FIELD_LSB]; // [R15]
  assign wd_word_hi = pwdata[`OPP_WORD_HI_MSB:`OPP_WORD_HI_LSB];

  assign wr_levels  = bus_wr & hit_levels & pstrb[0]; // [R2]
  assign wr_drv_lo  = bus_wr & hit_drv_lo & pstrb[0]; // [R6]
  assign wr_drv_hi  = bus_wr & ((hit_drv_hi & pstrb[0]) | (hit_drv_lo & pstrb[1])); // [R6]
  assign wr_func_lo = bus_wr & hit_func_lo & pstrb[0]; // [R7]
  assign wr_func_hi = bus_wr & ((hit_func_hi & pstrb[0]) | (hit_func_lo & pstrb[1])); // [R7]

  // ****************************************************************
  // Register file.
  // ****************************************************************
  opp_nib_t levels_q;
  opp_nib_t drv_lo_q;
  opp_nib_t drv_hi_q;
  opp_nib_t func_lo_q;
  opp_nib_t func_hi_q;

  // Every field resets to zero: Hi-Z drive, general function, low data.
  opp_nib_reg u_levels (  // [R5]
    .core_clk (core_clk),
    .nrst     (nrst),
    .ce       (ce),
    .wr_en    (wr_levels),
    .wdata    (wd_low),
    .q        (levels_q)
  );

  opp_nib_reg u_drv_lo (
    .core_clk (core_clk),
    .nrst     (nrst),
    .ce       (ce),
    .wr_en    (wr_drv_lo),
    .wdata    (wd_low),
    .q        (drv_lo_q)
  );

  opp_nib_reg u_drv_hi (
    .core_clk (core_clk),
    .nrst     (nrst),
    .ce       (ce),
    .wr_en    (wr_drv_hi),
    .wdata    (hit_drv_lo ? wd_word_hi : wd_low),
    .q        (drv_hi_q)
  );

  opp_nib_reg u_func_lo (
    .core_clk (core_clk),
    .nrst     (nrst),
    .ce       (ce),
    .wr_en    (wr_func_lo),
    .wdata    (wd_low),
    .q        (func_lo_q)
  );

  opp_nib_reg u_func_hi (
    .core_clk (core_clk),
    .nrst     (nrst),
    .ce       (ce),
    .wr_en    (wr_func_hi),
    .wdata    (hit_func_lo ? wd_word_hi : wd_low),
    .q        (func_hi_q)
  );

  // ****************************************************************
  // Read data; upper nibbles of each byte read as zero.
  // ****************************************************************
  logic [31:0] rd_mux;

  assign rd_mux = hit_levels  ? {28'h0000000, levels_q} :                        // [R2]
                  hit_drv_lo  ? {16'h0000, 4'h0, drv_hi_q, 4'h0, drv_lo_q} :     // [R6] [R15]
                  hit_drv_hi  ? {28'h0000000, drv_hi_q} :
                  hit_func_lo ? {16'h0000, 4'h0, func_hi_q, 4'h0, func_lo_q} :   // [R7] [R15]
                  hit_func_hi ? {28'h0000000, func_hi_q} : 32'h00000000;

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end
    else if (ce)
    begin
      pready_reg  <= setup_ph;
      pslverr_reg <= setup_ph & ~hit_any;
      prdata_reg  <= (setup_ph & ~pwrite) ? rd_mux : 32'h00000000;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  // ****************************************************************
  // Pin drivers, one per output pin; there is no input path at all.
  // ****************************************************************
  // Clock sources pass through a flop, so a fast clock is only carried
  // faithfully when it runs well below half the core clock.
  logic [3:0] alt_a_src;
  logic [3:0] alt_b_src;
  logic [3:0] alt_c_src;

  assign alt_a_src = {1'b0, 1'b0, fast_clock_out, slow_clock_out};        // [R8]
  assign alt_b_src = {timer_second_out, timer_first_out, pwm_ch_five, pwm_ch_four}; // [R9]
  assign alt_c_src = {pwm_ch_seven, pwm_ch_six, 1'b0, 1'b0};             // [R10]

  for (genvar i = 0; i < `OPP_PIN_CNT; i++)
  begin : g_pin  // [R1]
    opp_pin_drive #(
      .CODE_OK ((i < 2) ? 4'h7 : 4'hd)  // [R13] [R14]
    ) u_pin (
      .core_clk (core_clk),
      .nrst     (nrst),
      .ce       (ce),
      .level    (levels_q[i]),  // [R3]
      .func     (opp_func_t'({func_hi_q[i], func_lo_q[i]})),
      .drive    (opp_drive_t'({drv_hi_q[i], drv_lo_q[i]})),  // [R4]
      .alt_a    (alt_a_src[i]),
      .alt_b    (alt_b_src[i]),
      .alt_c    (alt_c_src[i]),
      .pin_out  (pin_out[i]),
      .pin_oe   (pin_oe[i]),
      .led_mode (led_drive_mode[i])
    );
  end

endmodule : opp_port_top

`default_nettype wire

// File: dv/opp_load_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Loads on the four output pins.
// ****************************************************************
module opp_load_model
(
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe,
  output logic [3:0]      pad,
  output logic [3:0]      led_lit
);
  // Each pin carries an LED to the supply, so an undriven pin floats to the rail.
  assign pad = (pin_out & pin_oe) | ~pin_oe;
  assign led_lit = ~pad;
endmodule : opp_load_model
`default_nettype wire

// File: dv/opp_port_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Bus handshake and pin checks.
// ****************************************************************
module opp_port_asserts
  import opp_pkg::*;
#(
  parameter int ADDR_W = 18
)
(
  input wire logic              core_clk,
  input wire logic              nrst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [3:0]        pin_out,
  input wire logic [3:0]        pin_oe,
  input wire logic [3:0]        led_drive_mode
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  property p_rdy;
    psel && !penable |=> pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ready held too long");
  property p_cause;
    pready |-> $past(psel && !penable);
  endproperty
  a_cause: assert property (p_cause) else $error("ready without setup");
  property p_err;
    pslverr |-> pready && prdata == 32'h0;
  endproperty
  a_err: assert property (p_err) else $error("error answer malformed");
  property p_quiet;
    !pready |-> prdata == 32'h0;
  endproperty
  a_quiet: assert property (p_quiet) else $error("read data outside access");
  property p_rsvd;
    pready && !pwrite |-> prdata[31:12] == 20'h0 && prdata[7:4] == 4'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
  property p_rst;
    $rose(nrst) |-> pin_out == 4'h0 && pin_oe == 4'h0 && led_drive_mode == 4'hf;
  endproperty
  a_rst: assert property (p_rst) else $error("pins wrong after reset");
  property p_lvl;
    psel && penable && pready && pwrite && paddr == 18'h3c8a0 && pstrb[0]
      |=> ##1 ((pin_out ^ $past(pwdata[3:0], 2)) & led_drive_mode) == 4'h0;
  endproperty
  a_lvl: assert property (p_lvl) else $error("pin level does not follow data");
endmodule : opp_port_asserts
bind opp_port_top opp_port_asserts #(.ADDR_W(ADDR_W)) i_opp_port_asserts (.core_clk, .nrst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .pin_out, .pin_oe, .led_drive_mode);
`default_nettype wire

// File: dv/opp_port_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define OPP_CHK(g, e) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("unexpected t=%0t got=%h exp=%h", $time, g, e); \
    end \
  end
module opp_port_tb_top;
  import opp_pkg::*;
  logic        core_clk, nrst, ce, psel, penable, pwrite, pready, pslverr, er;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd, d;
  logic [3:0]  pstrb, pin_out, pin_oe, led_drive_mode, pad;
  logic [7:0]  al;
  logic [3:0]  m [5];
  logic [17:0] ad [5] = '{18'h3c8a0, 18'h3c8a8, 18'h3c8ac, 18'h3c8b0, 18'h3c8b4};
  int          fail_count, cmp_count;
  opp_port_top i_opp_port_top (.core_clk(core_clk), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .slow_clock_out(al[0]), .fast_clock_out(al[1]), .pwm_ch_four(al[2]),
    .pwm_ch_five(al[3]), .pwm_ch_six(al[4]), .pwm_ch_seven(al[5]), .timer_first_out(al[6]),
    .timer_second_out(al[7]), .pin_out(pin_out), .pin_oe(pin_oe), .led_drive_mode(led_drive_mode));
  opp_load_model i_opp_load_model (.pin_out(pin_out), .pin_oe(pin_oe), .pad(pad), .led_lit());
  always #10 core_clk = ~core_clk;
  task tally_and_finish();
    if (fail_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  task apb(input logic w, input logic [17:0] a, input logic [31:0] wd, input logic [3:0] s);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20)
      fail_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Expected {led mode, enable, level} from the register model and the sources.
  function automatic logic [11:0] ex();
    logic [1:0] f, dr;
    logic       v;
    logic [3:0] o, e, l;
    for (int i = 0; i < 4; i++)
    begin
      f = {m[4][i], m[3][i]};
      dr = {m[2][i], m[1][i]};
      v = m[0][i];
      if (i < 2)
      begin
        if (f == 2'h1)
          v = al[i];
        if (f == 2'h2)
          v = al[2+i];
      end
      else
      begin
        if (f == 2'h2)
          v = al[4+i];
        if (f == 2'h3)
          v = al[2+i];
      end
      o[i] = v;
      e[i] = dr == 2'h3 || (dr == 2'h1 && v) || (dr == 2'h2 && !v);
      l[i] = f == 2'h0;
    end
    return {l, e, o};
  endfunction : ex
  task chk_pins();
    logic [11:0] x;
    repeat (3) @(posedge core_clk);
    x = ex();
    `OPP_CHK(pin_out, x[3:0])
    `OPP_CHK(pin_oe, x[7:4])
    `OPP_CHK(led_drive_mode, x[11:8])
    `OPP_CHK(pad, (x[3:0] & x[7:4]) | ~x[7:4])
  endtask : chk_pins
  task rdall();
    logic [31:0] xp;
    for (int k = 0; k < 5; k++)
    begin
      apb(1'b0, ad[k], 32'h0, 4'hf);
      xp = {28'h0, m[k]};
      if (k == 1 || k == 3)
        xp[11:8] = m[k+1];
      `OPP_CHK(rd, xp)
    end
  endtask : rdall
  initial
  begin
    core_clk = 0;
    nrst = 0;
    ce = 1;
    {psel, penable, pwrite, paddr, pwdata, pstrb, al} = '0;
    m = '{default: 4'h0};
    fail_count = 0;
    cmp_count = 0;
    void'($urandom(25));
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    `OPP_CHK(pin_oe, 4'h0)
    rdall();
    apb(1'b0, 18'h3c8a4, 32'h0, 4'hf);
    `OPP_CHK({er, rd}, {1'b1, 32'h0})
    m[2] = 4'hf;
    apb(1'b1, ad[1], 32'h0f00, 4'h3);
    chk_pins();
    for (int it = 0; it < 48; it++)
    begin
      for (int k = 0; k < 5; k++)
      begin
        if (it % 2 == 1 && (k == 2 || k == 4))
          continue;
        d = $urandom;
        m[k] = d[3:0];
        if (it % 2 == 1 && (k == 1 || k == 3))
          m[k+1] = d[11:8];
        apb(1'b1, ad[k], d, (it % 2 == 1) ? 4'h3 : 4'h1);
      end
      al <= $urandom;
      chk_pins();
      rdall();
    end
    d[3:0] = pin_out;
    ce <= 1'b0;
    al <= ~al;
    repeat (3) @(posedge core_clk);
    `OPP_CHK(pin_out, d[3:0])
    ce <= 1'b1;
    chk_pins();
    tally_and_finish();
  end
  initial
  begin
    #400000;
    fail_count++;
    tally_and_finish();
  end
endmodule : opp_port_tb_top
`default_nettype wire
